// File: shared/rdmc_pkg.sv
// shared constants, layouts and types of the delivery-method framer
package rdmc_pkg;
	// timing
	localparam int CLK_MHZ = 40;
	localparam int SESS_TICK_US = 1000;
	localparam int SESS_TICK_CYC = SESS_TICK_US * CLK_MHZ;
	localparam int ACK_WAIT_US = 500;
	localparam int ACK_WAIT_CYC = ACK_WAIT_US * CLK_MHZ;
	// frame layout
	localparam int PRE_REPS = 4;
	localparam int MAC_WORDS = 3;
	localparam int NET_WORDS = 3;
	localparam logic [2:0] PAY_SLOT = 3'h6;
	localparam logic [55:0] PRE_PATTERN = 56'hAAAAAAAAAAAAAA;
	localparam logic [63:0] BCAST_ADDR = 64'h000000000000FFFF;
	localparam int FLAG_ACK = 0;
	// delivery methods
	localparam logic [7:0] METHOD_P2MP = 8'h40;
	localparam logic [7:0] METHOD_REPEAT = 8'h80;
	localparam logic [7:0] METHOD_MESH = 8'hC0;
	// command codes
	localparam logic [7:0] CMD_ENTER = 8'h01;
	localparam logic [7:0] CMD_COMMIT = 8'h02;
	localparam logic [7:0] CMD_LEAVE = 8'h03;
	localparam logic [7:0] CHAR_CR = 8'h0D;
	// register byte offsets
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_RATE = 8'h08;
	localparam logic [7:0] REG_PRE = 8'h0C;
	localparam logic [7:0] REG_NET = 8'h10;
	localparam logic [7:0] REG_RETRY = 8'h14;
	localparam logic [7:0] REG_BCX = 8'h18;
	localparam logic [7:0] REG_DSTHI = 8'h1C;
	localparam logic [7:0] REG_DSTLO = 8'h20;
	localparam logic [7:0] REG_METHOD = 8'h24;
	localparam logic [7:0] REG_HOPS = 8'h28;
	localparam logic [7:0] REG_ROUTE = 8'h2C;
	localparam logic [7:0] REG_SESSTO = 8'h30;
	localparam logic [7:0] REG_SERHI = 8'h34;
	localparam logic [7:0] REG_SERLO = 8'h38;
	localparam logic [7:0] REG_TXDATA = 8'h3C;
	localparam logic [7:0] REG_SEND = 8'h40;
	localparam logic [7:0] REG_RXSRCHI = 8'h44;
	localparam logic [7:0] REG_RXSRCLO = 8'h48;
	localparam logic [7:0] REG_RXDATA = 8'h4C;
	typedef enum logic [1:0] {
		SEG_PRE = 2'b00, SEG_MAC = 2'b01, SEG_NET = 2'b10, SEG_PAY = 2'b11
	} rdmc_seg_t;
	typedef struct packed {
		rdmc_seg_t kind;
		logic last;
		logic [63:0] data;
	} rdmc_word_t;
	typedef struct packed {
		logic [7:0] lineRate;
		logic [7:0] preTag;
		logic [15:0] netTag;
		logic [7:0] retries;
		logic [7:0] bcExtra;
		logic [31:0] dstHi;
		logic [31:0] dstLo;
		logic [7:0] method;
		logic [7:0] maxHops;
		logic routeEn;
		logic [15:0] sessTimeout;
	} rdmc_cfg_t;
	localparam rdmc_cfg_t CFG_RESET = '{lineRate: 8'h03, preTag: 8'h00,
		netTag: 16'h0001, retries: 8'h0A, bcExtra: 8'h03, dstHi: 32'h0,
		dstLo: 32'h0000FFFF, method: 8'h40, maxHops: 8'h07, routeEn: 1'b1,
		sessTimeout: 16'h2710};
	typedef struct packed {
		logic [7:0] method;
		logic isAck;
		logic [15:0] seq;
		logic [7:0] hops;
		logic [63:0] orig;
		logic [63:0] dst;
		logic [63:0] payload;
	} rdmc_job_t;
endpackage : rdmc_pkg

// File: core/rdmc_core.sv
// framer core: config session, tx sequencing, rx filtering, relay
//
// Summary of operation
// - written settings wait for commit or leave
// - leave on command plus CR, or timeout
// - radio either receives or transmits, never both
// - frame: preamble, MAC header, network header, payload
// - ignore preamble with foreign group tag
// - accept frame only if network group matches
// - unicast attempts bounded by retry setting
// - own 64-bit address, reported as sender
// - all-zero upper, FFFF lower means broadcast
// - method codes 0x40, 0x80, 0xC0
// - options zero or transparent use default method
// - point-to-multipoint: MAC only, never relayed
// - p2mp broadcast sent extra-sends plus one
// - every p2mp broadcast receiver delivers payload
// - repeater broadcasts unacked, four sends default
// - repeater adds network header, drops duplicates
// - repeater unicast: broadcast, only target delivers
// - routing nodes relay while hop budget remains
// - max hops bound, smaller frame budget wins
// - routing enabled by default, switchable per node
// - MAC generates, checks acks, drops duplicates
//
// The implementer's own choices: the Wishbone register port and the address map.
`timescale 1ns/1ps
module rdmc_core import rdmc_pkg::*; #(
	parameter int SESS_TICK = SESS_TICK_CYC,
	parameter int ACK_WAIT = ACK_WAIT_CYC,
	parameter logic [31:0] SERIAL_UPPER = 32'h00C0FFEE, // arbitrary
	parameter logic [31:0] SERIAL_LOWER = 32'h12345678 // arbitrary
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// wishbone classic slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// radio link, transmit words
	output logic txValid,
	output rdmc_word_t txWord,
	input wire logic linkReady,
	// radio link, received words
	input wire logic rxValid,
	input wire rdmc_word_t rxWord,
	// radio state and active settings
	output logic radioTx,
	output logic radioRx,
	output logic [7:0] lineRate
);
	localparam logic [63:0] SELF = {SERIAL_UPPER, SERIAL_LOWER};
	localparam int DUP_N = 4;
	typedef enum logic [1:0] {
		TX_IDLE = 2'b00, TX_SEND = 2'b01, TX_WAIT = 2'b10
	} rdmc_txst_t;

	function automatic logic [31:0] mergeSel(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) r[8*b +: 8] = nw[8*b +: 8];
		end
		return r;
	endfunction : mergeSel

	function automatic logic [4:0] wordCount(input rdmc_job_t j);
		logic [4:0] n;
		n = 5'(PRE_REPS + MAC_WORDS);
		if (j.method != METHOD_P2MP && !j.isAck) n = n + 5'(NET_WORDS);
		if (!j.isAck) n = n + 5'h01;
		return n;
	endfunction : wordCount

	function automatic rdmc_word_t buildWord(input rdmc_job_t j,
		input logic [4:0] idx, input logic [7:0] pre, input logic [15:0] net);
		rdmc_word_t w;
		logic [4:0] k;
		logic bc;
		k = idx - 5'(PRE_REPS);
		bc = j.method != METHOD_P2MP || j.dst == BCAST_ADDR;
		w.last = idx == wordCount(j) - 5'h01;
		w.kind = SEG_PAY;
		w.data = j.payload;
		if (idx < 5'(PRE_REPS)) begin
			w.kind = SEG_PRE;
			w.data = {PRE_PATTERN, pre};
		end else if (k < 5'(MAC_WORDS)) begin
			w.kind = SEG_MAC;
			case (k)
			5'h00: w.data = {net, j.method, 7'h00, j.isAck, j.seq, 16'h0};
			5'h01: w.data = SELF;
			default: w.data = bc ? BCAST_ADDR : j.dst;
			endcase
		end else if (j.method != METHOD_P2MP && !j.isAck &&
			k < 5'(MAC_WORDS + NET_WORDS)) begin
			w.kind = SEG_NET;
			case (k)
			5'h03: w.data = {j.hops, 56'h0};
			5'h04: w.data = j.orig;
			default: w.data = j.dst;
			endcase
		end
		return w;
	endfunction : buildWord

	////////////////////////////////////////////////////////////////////////
	// register bus
	rdmc_cfg_t pend, act;
	logic inSession, apply, timedOut, tick;
	logic [31:0] tickCnt;
	logic [15:0] sessMs;
	logic [63:0] txData, rxSrc, rxData;
	logic rxHave, hostReq, lastOk, lastFail, jobValid;
	logic [7:0] hostOpts, hostBudget;
	logic wbTake, wbWr, cmdWr, enterCmd, commitCmd, leaveCmd;
	logic deliver;
	logic [31:0] rdData;

	assign wbTake = cyc_i && stb_i && !ack_o;
	assign wbWr = wbTake && we_i;
	assign cmdWr = wbWr && adr_i == REG_CMD && sel_i[0];
	assign enterCmd = cmdWr && dat_i[7:0] == CMD_ENTER;
	assign commitCmd = cmdWr && inSession && dat_i[7:0] == CMD_COMMIT;
	assign leaveCmd = cmdWr && inSession && dat_i[7:0] == CMD_LEAVE &&
		dat_i[15:8] == CHAR_CR;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0;
		end else begin
			ack_o <= wbTake;
			dat_o <= wbTake && !we_i ? rdData : 32'h0;
		end
	end

	always_comb begin
		case (adr_i)
		REG_STATUS: rdData = {26'h0, tx_state_busy(), rxHave, lastFail, lastOk,
			jobValid, inSession};
		REG_RATE: rdData = {24'h0, pend.lineRate};
		REG_PRE: rdData = {24'h0, pend.preTag};
		REG_NET: rdData = {16'h0, pend.netTag};
		REG_RETRY: rdData = {24'h0, pend.retries};
		REG_BCX: rdData = {24'h0, pend.bcExtra};
		REG_DSTHI: rdData = pend.dstHi;
		REG_DSTLO: rdData = pend.dstLo;
		REG_METHOD: rdData = {24'h0, pend.method};
		REG_HOPS: rdData = {24'h0, pend.maxHops};
		REG_ROUTE: rdData = {31'h0, pend.routeEn};
		REG_SESSTO: rdData = {16'h0, pend.sessTimeout};
		REG_SERHI: rdData = SERIAL_UPPER;
		REG_SERLO: rdData = SERIAL_LOWER;
		REG_TXDATA: rdData = txData[31:0];
		REG_RXSRCHI: rdData = rxSrc[63:32];
		REG_RXSRCLO: rdData = rxSrc[31:0];
		REG_RXDATA: rdData = rxData[31:0];
		default: rdData = 32'h0;
		endcase
	end

	// settings land in the pending copy only, and only inside a session
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			pend <= CFG_RESET;
		end else if (wbWr && inSession) begin
			case (adr_i)
			REG_RATE: pend.lineRate <= 8'(mergeSel(32'(pend.lineRate), dat_i,
				sel_i));
			REG_PRE: pend.preTag <= 8'(mergeSel(32'(pend.preTag), dat_i, sel_i));
			REG_NET: pend.netTag <= 16'(mergeSel(32'(pend.netTag), dat_i,
				sel_i));
			REG_RETRY: pend.retries <= 8'(mergeSel(32'(pend.retries), dat_i,
				sel_i));
			REG_BCX: pend.bcExtra <= 8'(mergeSel(32'(pend.bcExtra), dat_i,
				sel_i));
			REG_DSTHI: pend.dstHi <= mergeSel(pend.dstHi, dat_i, sel_i);
			REG_DSTLO: pend.dstLo <= mergeSel(pend.dstLo, dat_i, sel_i);
			REG_METHOD: pend.method <= 8'(mergeSel(32'(pend.method), dat_i,
				sel_i));
			REG_HOPS: pend.maxHops <= 8'(mergeSel(32'(pend.maxHops), dat_i,
				sel_i));
			REG_ROUTE: pend.routeEn <= sel_i[0] ? dat_i[0] : pend.routeEn;
			REG_SESSTO: pend.sessTimeout <= 16'(mergeSel(32'(pend.sessTimeout),
				dat_i, sel_i));
			default: pend <= pend;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// configuration session
	assign timedOut = inSession && tick && sessMs + 16'h0001 >=
		act.sessTimeout;
	assign apply = commitCmd || leaveCmd || timedOut;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			tickCnt <= 32'h0;
			tick <= 1'b0;
		end else begin
			tick <= tickCnt == 32'(SESS_TICK - 2);
			tickCnt <= tickCnt == 32'(SESS_TICK - 1) ? 32'h0 : tickCnt + 32'h1;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			inSession <= 1'b0;
			sessMs <= 16'h0;
		end else if (enterCmd) begin
			inSession <= 1'b1;
			sessMs <= 16'h0;
		end else if (leaveCmd || timedOut) begin
			inSession <= 1'b0;
			sessMs <= 16'h0;
		end else if (inSession && wbWr) begin
			sessMs <= 16'h0;
		end else if (inSession && tick) begin
			sessMs <= sessMs + 16'h0001;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			act <= CFG_RESET;
			lineRate <= CFG_RESET.lineRate;
		end else if (apply) begin
			act <= pend;
			lineRate <= pend.lineRate;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// receive path
	logic [63:0] rxSlot [0:6];
	logic [2:0] slot;
	logic locked, evalNow;
	logic [63:0] dupSrc [0:DUP_N-1];
	logic [15:0] dupSeq [0:DUP_N-1];
	logic [DUP_N-1:0] dupValid;
	logic [1:0] dupPtr;
	logic [7:0] rMethod;
	logic [15:0] rSeq;
	logic [63:0] rOrig, rDst, rMacDst;
	logic rRep, rAck, isDup, forMe, needAck, relay, gotAck;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			locked <= 1'b0;
			slot <= 3'h0;
			evalNow <= 1'b0;
			for (int i = 0; i < 7; i++) rxSlot[i] <= 64'h0;
		end else begin
			evalNow <= 1'b0;
			if (radioTx) begin
				locked <= 1'b0;
			end else if (rxValid) begin
				if (rxWord.kind == SEG_PRE) begin
					locked <= rxWord.data == {PRE_PATTERN, act.preTag};
					slot <= 3'h0;
				end else if (locked) begin
					rxSlot[rxWord.kind == SEG_PAY ? PAY_SLOT : slot] <= rxWord.data;
					slot <= slot + 3'h1;
					if (slot == 3'h0 && rxWord.data[63:48] != act.netTag)
						locked <= 1'b0;
					else if (rxWord.last) begin
						locked <= 1'b0;
						evalNow <= 1'b1;
					end
				end
			end
		end
	end

	assign rMethod = rxSlot[0][47:40];
	assign rAck = rxSlot[0][32 + FLAG_ACK];
	assign rSeq = rxSlot[0][31:16];
	assign rMacDst = rxSlot[2];
	assign rRep = rMethod != METHOD_P2MP;
	assign rOrig = rRep ? rxSlot[4] : rxSlot[1];
	assign rDst = rRep ? rxSlot[5] : rMacDst;
	assign forMe = rDst == SELF || rDst == BCAST_ADDR;

	always_comb begin
		isDup = 1'b0;
		for (int i = 0; i < DUP_N; i++) begin
			if (dupValid[i] && dupSrc[i] == rOrig && dupSeq[i] == rSeq)
				isDup = 1'b1;
		end
	end

	assign deliver = evalNow && !rAck && forMe && !isDup;
	assign needAck = evalNow && !rAck && !rRep && rMacDst == SELF;
	// relays only repeater and mesh frames; p2mp receivers never repeat
	assign relay = evalNow && !rAck && rRep && !isDup && act.routeEn &&
		rxSlot[3][63:56] != 8'h00 && rDst != SELF;

	// round robin replaces the oldest entry once all are valid
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			dupValid <= '0;
			dupPtr <= 2'h0;
			for (int i = 0; i < DUP_N; i++) begin
				dupSrc[i] <= 64'h0;
				dupSeq[i] <= 16'h0;
			end
		end else if (evalNow && !rAck && !isDup) begin
			dupValid[dupPtr] <= 1'b1;
			dupSrc[dupPtr] <= rOrig;
			dupSeq[dupPtr] <= rSeq;
			dupPtr <= dupPtr + 2'h1;
		end
	end

	// a delivery in the cycle of the clearing read wins
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rxHave <= 1'b0;
			rxSrc <= 64'h0;
			rxData <= 64'h0;
		end else if (deliver) begin
			rxHave <= 1'b1;
			rxSrc <= rOrig;
			rxData <= rxSlot[PAY_SLOT];
		end else if (wbTake && !we_i && adr_i == REG_RXDATA) begin
			rxHave <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// transmit job and sequencer
	rdmc_txst_t txState;
	rdmc_job_t job, relayJob, ackJob;
	logic relayReq, ackReq;
	logic [4:0] idx;
	logic [7:0] sendsLeft, attempts;
	logic [31:0] waitCnt;
	logic [15:0] seqNum;
	logic [7:0] hostMethod, hostHops;

	function automatic logic tx_state_busy();
		return txState != TX_IDLE;
	endfunction : tx_state_busy

	assign hostMethod = hostOpts == 8'h00 ? act.method : hostOpts;
	assign hostHops = hostBudget != 8'h00 && hostBudget < act.maxHops ?
		hostBudget : act.maxHops;
	assign gotAck = evalNow && rAck && txState == TX_WAIT &&
		rMacDst == SELF && rSeq == job.seq;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			hostReq <= 1'b0;
			hostOpts <= 8'h00;
			hostBudget <= 8'h00;
			txData <= 64'h0;
		end else if (wbWr && adr_i == REG_TXDATA) begin
			txData <= {32'h0, mergeSel(txData[31:0], dat_i, sel_i)};
		end else if (wbWr && adr_i == REG_SEND && !hostReq) begin
			hostReq <= 1'b1;
			hostOpts <= dat_i[7:0];
			hostBudget <= dat_i[15:8];
		end else if (hostReq && !jobValid && !ackReq && !relayReq) begin
			hostReq <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ackReq <= 1'b0;
			relayReq <= 1'b0;
			ackJob <= '0;
			relayJob <= '0;
		end else begin
			if (needAck) begin
				ackReq <= 1'b1;
				ackJob <= '{method: METHOD_P2MP, isAck: 1'b1, seq: rSeq,
					hops: 8'h00, orig: SELF, dst: rxSlot[1], payload: 64'h0};
			end else if (!jobValid) begin
				ackReq <= 1'b0;
			end
			if (relay && !relayReq) begin
				relayReq <= 1'b1;
				relayJob <= '{method: rMethod, isAck: 1'b0, seq: rSeq,
					hops: rxSlot[3][63:56] - 8'h01, orig: rOrig, dst: rDst,
					payload: rxSlot[PAY_SLOT]};
			end else if (!jobValid && !ackReq) begin
				relayReq <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			txState <= TX_IDLE;
			jobValid <= 1'b0;
			job <= '0;
			idx <= 5'h0;
			sendsLeft <= 8'h0;
			attempts <= 8'h0;
			waitCnt <= 32'h0;
			seqNum <= 16'h0;
			txValid <= 1'b0;
			txWord <= '0;
			radioTx <= 1'b0;
			radioRx <= 1'b1;
			lastOk <= 1'b0;
			lastFail <= 1'b0;
		end else begin
			case (txState)
			TX_IDLE: begin
				if (!jobValid && (ackReq || relayReq || hostReq)) begin
					jobValid <= 1'b1;
					if (ackReq) begin
						job <= ackJob;
						sendsLeft <= 8'h01;
					end else if (relayReq) begin
						job <= relayJob;
						sendsLeft <= act.bcExtra + 8'h01;
					end else begin
						job <= '{method: hostMethod, isAck: 1'b0, seq: seqNum,
							hops: hostHops, orig: SELF, dst: {act.dstHi, act.dstLo},
							payload: txData};
						seqNum <= seqNum + 16'h0001;
						// unicast p2mp counts attempts instead of repeats
						sendsLeft <= act.bcExtra + 8'h01;
					end
					attempts <= 8'h01;
				end else if (jobValid) begin
					idx <= 5'h0;
					txWord <= buildWord(job, 5'h0, act.preTag, act.netTag);
					txValid <= 1'b1;
					radioTx <= 1'b1;
					radioRx <= 1'b0;
					txState <= TX_SEND;
				end
			end
			TX_SEND: begin
				if (linkReady) begin
					if (!txWord.last) begin
						idx <= idx + 5'h01;
						txWord <= buildWord(job, idx + 5'h01, act.preTag, act.netTag);
					end else if (job.method == METHOD_P2MP && !job.isAck &&
						job.dst != BCAST_ADDR) begin
						txValid <= 1'b0;
						radioTx <= 1'b0;
						radioRx <= 1'b1;
						waitCnt <= 32'h0;
						txState <= TX_WAIT;
					end else if (sendsLeft > 8'h01) begin
						sendsLeft <= sendsLeft - 8'h01;
						idx <= 5'h0;
						txWord <= buildWord(job, 5'h0, act.preTag, act.netTag);
					end else begin
						txValid <= 1'b0;
						radioTx <= 1'b0;
						radioRx <= 1'b1;
						jobValid <= 1'b0;
						lastOk <= !job.isAck ? 1'b1 : lastOk;
						lastFail <= !job.isAck ? 1'b0 : lastFail;
						txState <= TX_IDLE;
					end
				end
			end
			TX_WAIT: begin
				waitCnt <= waitCnt + 32'h1;
				if (gotAck) begin
					jobValid <= 1'b0;
					lastOk <= 1'b1;
					lastFail <= 1'b0;
					txState <= TX_IDLE;
				end else if (waitCnt == 32'(ACK_WAIT - 1)) begin
					if (attempts < act.retries) begin
						attempts <= attempts + 8'h01;
						txState <= TX_IDLE;
					end else begin
						jobValid <= 1'b0;
						lastOk <= 1'b0;
						lastFail <= 1'b1;
						txState <= TX_IDLE;
					end
				end
			end
			default: txState <= TX_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	sequence s_leave_req;
		inSession && cmdWr && dat_i[7:0] == CMD_LEAVE && dat_i[15:8] == CHAR_CR;
	endsequence
	sequence s_frame_start;
		$rose(txValid);
	endsequence

	a_radio_one_state: assert property (radioTx != radioRx)
		else $error("radio in both or neither state");
	a_settings_held: assert property ($changed(act) |-> $past(apply))
		else $error("active settings changed without apply");
	a_leave_ends: assert property (s_leave_req |=>
		!inSession && act == $past(pend))
		else $error("leave command did not end session");
	a_timeout_ends: assert property (timedOut |=> !inSession)
		else $error("session survived timeout");
	a_preamble_first: assert property (s_frame_start |->
		txWord.kind == SEG_PRE)
		else $error("frame did not open with preamble");
	a_payload_last: assert property (txValid &&
		txWord.kind == SEG_PAY |-> txWord.last)
		else $error("payload not last segment");
	a_p2mp_no_net: assert property (txValid &&
		txWord.kind == SEG_NET |-> job.method != METHOD_P2MP)
		else $error("network header in p2mp frame");
	a_attempt_bound: assert property (txState == TX_WAIT |->
		attempts <= act.retries || act.retries == 8'h00)
		else $error("too many unicast attempts");
	a_no_rx_in_tx: assert property (radioTx |=> !evalNow)
		else $error("frame accepted while transmitting");
	a_deliver_net: assert property (deliver |->
		rxSlot[0][63:48] == act.netTag)
		else $error("delivered frame of foreign network");
endmodule : rdmc_core

// File: tb/rdmc_radio.sv
// peer radio model: link back-pressure and received frames
`timescale 1ns/1ps
module rdmc_radio import rdmc_pkg::*; (
	// clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// radio link
	input wire logic txValid,
	output logic linkReady,
	output logic rxValid,
	output rdmc_word_t rxWord
);
	initial begin
		linkReady = 1'b0;
		rxValid = 1'b0;
		rxWord = '0;
	end
	// random stalls exercise the held-word contract
	always @(posedge clk_sys) begin
		linkReady <= resetn && ($urandom % 4 != 0);
	end
	task automatic put(input rdmc_seg_t k, input logic l, input logic [63:0] d);
		rxValid <= 1'b1;
		rxWord <= '{kind: k, last: l, data: d};
		@(posedge clk_sys);
		rxValid <= 1'b0;
		// idle line shows garbage, not the last word
		rxWord.data <= ~d;
		@(posedge clk_sys);
	endtask : put
	task automatic frame(input logic [7:0] pre, input logic [15:0] net,
		input logic [63:0] src, input logic [63:0] pay);
		for (int i = 0; i < PRE_REPS; i++) begin
			put(SEG_PRE, 1'b0, {PRE_PATTERN, pre});
		end
		put(SEG_MAC, 1'b0, {net, METHOD_P2MP, 8'h00, 16'h0001, 16'h0000});
		put(SEG_MAC, 1'b0, src);
		put(SEG_MAC, 1'b0, BCAST_ADDR);
		put(SEG_PAY, 1'b1, pay);
		repeat (4) @(posedge clk_sys);
	endtask : frame
endmodule : rdmc_radio

// File: tb/test_radio_delivery_method_control.sv
// self-checking bench of the delivery-method framer
`timescale 1ns/1ps
module test_radio_delivery_method_control import rdmc_pkg::*;;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic ack, txValid, linkReady, rxValid, radioTx, radioRx;
	logic [7:0] lineRate;
	rdmc_word_t txWord, rxWord;
	logic [31:0] expR[$];
	logic [67:0] expK[$];
	logic [67:0] expW;
	logic [31:0] txd;
	int failures = 0;
	int checked = 0;
	logic [63:0] src, pay;
	localparam logic [31:0] SER_HI = 32'h0000A5C3; // arbitrary
	localparam logic [31:0] SER_LO = 32'h5E1F0042; // arbitrary

	always #12.5 clk_sys = ~clk_sys;

	rdmc_core #(.SESS_TICK(10), .ACK_WAIT(20), .SERIAL_UPPER(SER_HI),
		.SERIAL_LOWER(SER_LO)) i_rdmc_core (
		.clk_sys(clk_sys), .resetn(resetn), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o(rdat),
		.ack_o(ack), .txValid(txValid), .txWord(txWord),
		.linkReady(linkReady), .rxValid(rxValid), .rxWord(rxWord),
		.radioTx(radioTx), .radioRx(radioRx), .lineRate(lineRate));
	rdmc_radio i_rdmc_radio (.clk_sys(clk_sys), .resetn(resetn),
		.txValid(txValid), .linkReady(linkReady), .rxValid(rxValid),
		.rxWord(rxWord));

	////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : print_verdict
	task automatic chk(input string what, input logic [31:0] e,
		input logic [31:0] g);
		checked++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk_sys);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) begin
			failures++;
			print_verdict();
		end
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_sys);
	endtask : wb
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		expR.push_back(e);
		wb(1'b0, a, 32'h0);
	endtask : rd
	// one note per link word: check-low flag, kind, last, data
	task automatic send(input logic [15:0] opt, input logic [7:0] meth,
		input int reps, input logic [7:0] hops, input logic [63:0] dst);
		int n;
		logic net;
		net = meth != METHOD_P2MP;
		for (int r = 0; r < reps; r++) begin
			for (int i = 0; i < PRE_REPS; i++) begin
				expK.push_back({1'b1, SEG_PRE, 1'b0, PRE_PATTERN, 8'h00});
			end
			// sequence number start is free, so its low half is unchecked
			expK.push_back({1'b0, SEG_MAC, 1'b0, 16'h0001, meth, 40'h0});
			expK.push_back({1'b1, SEG_MAC, 1'b0, SER_HI, SER_LO});
			expK.push_back({1'b1, SEG_MAC, 1'b0, net ? BCAST_ADDR : dst});
			if (net) begin
				expK.push_back({1'b1, SEG_NET, 1'b0, hops, 56'h0});
				expK.push_back({1'b1, SEG_NET, 1'b0, SER_HI, SER_LO});
				expK.push_back({1'b1, SEG_NET, 1'b0, dst});
			end
			expK.push_back({1'b1, SEG_PAY, 1'b1, 32'h0, txd});
		end
		wb(1'b1, REG_SEND, {16'h0, opt});
		n = 0;
		while (expK.size() > 0 && n < 2000) begin
			@(posedge clk_sys);
			n++;
		end
		if (n >= 2000) begin
			failures++;
			print_verdict();
		end
		repeat (4) @(posedge clk_sys);
	endtask : send

	////////////////////////////////////////////////////////////////////
	// monitor: oldest note against each result as it appears
	always @(posedge clk_sys) begin
		if (ack === 1'b1 && we === 1'b0) begin
			chk("read data", expR.size() ? expR.pop_front() : '1, rdat);
		end
		if (txValid === 1'b1 && linkReady === 1'b1) begin
			chk("radio state", {31'h0, ~radioTx}, {31'h0, radioRx});
			expW = expK.size() ? expK.pop_front() : '1;
			chk("tx word", {29'h0, expW[66:64]},
				{29'h0, txWord.kind, txWord.last});
			chk("tx data hi", expW[63:32], txWord.data[63:32]);
			if (expW[67]) chk("tx data lo", expW[31:0], txWord.data[31:0]);
		end
	end

	initial begin
		void'($urandom(68));
		repeat (10) @(posedge clk_sys);
		resetn <= 1'b1;
		@(posedge clk_sys);
		chk("line rate", 32'h3, {24'h0, lineRate});
		rd(REG_NET, 32'h1);
		rd(REG_METHOD, {24'h0, METHOD_P2MP});
		rd(REG_SERHI, SER_HI);
		rd(REG_SERLO, SER_LO);
		$display("test reset values done");
		wb(1'b1, REG_CMD, {24'h0, CMD_ENTER});
		wb(1'b1, REG_RATE, 32'h5);
		rd(REG_RATE, 32'h5);
		chk("line rate", 32'h3, {24'h0, lineRate});
		wb(1'b1, REG_CMD, {16'h0, CHAR_CR, CMD_LEAVE});
		repeat (2) @(posedge clk_sys);
		chk("line rate", 32'h5, {24'h0, lineRate});
		wb(1'b1, REG_RATE, 32'h7);
		rd(REG_RATE, 32'h5);
		wb(1'b1, REG_CMD, {24'h0, CMD_ENTER});
		wb(1'b1, REG_SESSTO, 32'h2);
		wb(1'b1, REG_CMD, {24'h0, CMD_COMMIT});
		wb(1'b1, REG_RATE, 32'h9);
		rd(REG_RATE, 32'h9);
		chk("line rate", 32'h5, {24'h0, lineRate});
		// two ticks of ten cycles, with margin
		repeat (40) @(posedge clk_sys);
		chk("line rate", 32'h9, {24'h0, lineRate});
		wb(1'b1, REG_RATE, 32'h1);
		rd(REG_RATE, 32'h9);
		$display("test config session done");
		txd = $urandom;
		wb(1'b1, REG_TXDATA, txd);
		send(16'h0000, METHOD_P2MP, 4, 8'h00, BCAST_ADDR);
		send({8'h00, METHOD_REPEAT}, METHOD_REPEAT, 4, 8'h07,
			BCAST_ADDR);
		send({8'h03, METHOD_MESH}, METHOD_MESH, 4, 8'h03,
			BCAST_ADDR);
		$display("test broadcast sends done");
		src = {$urandom, $urandom};
		pay = {$urandom, $urandom};
		i_rdmc_radio.frame(8'h00, 16'h0001, src, pay);
		rd(REG_RXSRCHI, src[63:32]);
		rd(REG_RXSRCLO, src[31:0]);
		rd(REG_RXDATA, pay[31:0]);
		i_rdmc_radio.frame(8'h00, 16'h0001, src, ~pay);
		rd(REG_RXDATA, pay[31:0]);
		i_rdmc_radio.frame(8'h5A, 16'h0001, ~src, ~pay);
		rd(REG_RXSRCLO, src[31:0]);
		i_rdmc_radio.frame(8'h00, 16'h0002, ~src, ~pay);
		rd(REG_RXSRCLO, src[31:0]);
		$display("test receive filtering done");
		wb(1'b1, REG_CMD, {24'h0, CMD_ENTER});
		wb(1'b1, REG_RETRY, 32'h2);
		wb(1'b1, REG_DSTHI, src[63:32]);
		wb(1'b1, REG_DSTLO, src[31:0]);
		wb(1'b1, REG_CMD, {16'h0, CHAR_CR, CMD_LEAVE});
		// nobody answers, so both attempts go out and the job fails
		send(16'h0000, METHOD_P2MP, 2, 8'h00, src);
		repeat (30) @(posedge clk_sys);
		rd(REG_STATUS, 32'h8);
		$display("test unicast retries done");
		print_verdict();
	end
endmodule : test_radio_delivery_method_control
